// File: design/adc_seq_pkg.sv
// Shared constants, types and decode helpers for the conversion sequencer
package adc_seq_pkg;
    // Clock and conversion timing
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int CONV_TIME_NS    = 10000;
    localparam int CONV_CYCLES     = (CONV_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int CYCLES_PER_US   = 1000 / CLOCK_PERIOD_NS;
    // Register reset values
    localparam logic [4:0] CHSEL_RESET = 5'h00;
    localparam logic [3:0] BLANK_RESET = 4'h0;
    localparam logic [7:0] RESULT_RESET = 8'h00;
    // Channel codes
    localparam logic [4:0] CODE_HIGHEST_OUTPUT_CHANNEL   = 5'h06;
    localparam logic [4:0] CODE_FIRST_PIN = 5'h08;
    // Scan bookkeeping
    localparam logic [3:0] GROUP_END   = 4'h8;
    localparam logic [3:0] SCAN_STARTS = 4'h9;
    localparam int         TIME_W      = 20;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_IDLE, ST_CHECK, ST_WAIT_CYCLE, ST_WAIT_ON, ST_BLANK, ST_CONVERT
    } state_type;

    // Request to the analog converter
    typedef struct packed {
        logic       start;
        logic [4:0] channel;
    } sar_req_type;

    // Blanking delay in microseconds for each field code
    function automatic logic [11:0] blank_us(input logic [3:0] code);
        logic [11:0] us;
        us = 12'd100;
        unique case (code)
            4'h0: us = 12'd100;
            4'h1: us = 12'd20;
            4'h2: us = 12'd30;
            4'h3: us = 12'd50;
            4'h4: us = 12'd80;
            4'h5: us = 12'd150;
            4'h6: us = 12'd200;
            4'h7: us = 12'd300;
            4'h8: us = 12'd500;
            4'h9: us = 12'd800;
            4'hA: us = 12'd1000;
            4'hB: us = 12'd1200;
            4'hC: us = 12'd1500;
            4'hD: us = 12'd2000;
            4'hE: us = 12'd3000;
            4'hF: us = 12'd4000;
        endcase
        return us;
    endfunction : blank_us

    // True for codes that pick an output pin (pairs, then a reserved code)
    function automatic logic is_pin_code(input logic [4:0] code);
        logic [4:0] off;
        off = code - CODE_FIRST_PIN;
        return (code >= CODE_FIRST_PIN) && (off % 5'd3 != 5'd2);
    endfunction : is_pin_code

    // Pin index {group, member} for a pin code
    function automatic logic [3:0] pin_of_code(input logic [4:0] code);
        logic [4:0] off;
        logic [4:0] grp;
        logic [4:0] mem;
        off = code - CODE_FIRST_PIN;
        grp = off / 5'd3;
        // Member is the remainder within a run of three codes, not the low offset bit
        mem = off - grp * 5'd3;
        return {grp[2:0], mem[0]};
    endfunction : pin_of_code

    // Channel code for a pin index
    function automatic logic [4:0] code_of_pin(input logic [3:0] pin);
        return CODE_FIRST_PIN + 5'(pin[3:1]) * 5'd3 + 5'(pin[0]);
    endfunction : code_of_pin
endpackage : adc_seq_pkg

// File: design/adc_conversion_sequencer.sv
// Conversion sequencer: single shots, max-output auto-scan and timing check
// How it works
// - Select write clears done, starts one conversion
// - Finished conversion loads result, sets done
// - Result read clears done, converts again
// - Codes 00h-05h internal channels, 07h reserved
// - Codes 08h-1Eh pin pairs, reserved between
// - Enabled pin sampled after turn-on plus blanking
// - Disabled pin sampled while off
// - Code 06h scans, keeps highest pin voltage
// - One pin pair per dimming cycle, eight groups
// - Scan result only after nine cycles
// - All groups done sets flag, scan stops
// - Result read restarts scan on code 06h
// - Select write during scan clears, restarts
// - Disabled pins skipped from scan maximum
// - Each start compares period with blank plus three
// - Short period aborts and sets error flag
// - Error flag cleared only by fault clear
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer #(
    parameter int CYCLES_PER_US = adc_seq_pkg::CYCLES_PER_US
) (
    // Clock and reset
    input  wire logic                     i_clock,
    input  wire logic                     i_resetn,
    // Register access
    input  wire logic                     i_select_write,
    input  wire logic [4:0]               i_select_data,
    input  wire logic                     i_blank_write,
    input  wire logic [3:0]               i_blank_data,
    input  wire logic                     i_result_read,
    input  wire logic                     i_fault_clear,
    output logic [4:0]                    o_channel_select,
    output logic [3:0]                    o_sample_blanking_delay,
    output logic [7:0]                    o_conversion_result,
    output logic                          o_conversion_done_flag,
    output logic                          o_converter_error_flag,
    // Output stage status
    input  wire logic [15:0]              i_output_enable_bit,
    input  wire logic [15:0]              i_output_on,
    input  wire logic                     i_dim_cycle_start,
    // Analog converter
    output adc_seq_pkg::sar_req_type      o_sar_request,
    input  wire logic                     i_sar_done,
    input  wire logic [7:0]               i_sar_code
);
    localparam int TW = adc_seq_pkg::TIME_W;

    adc_seq_pkg::state_type state_ff;        // Sequencer state
    logic [4:0]             sel_ff;          // Channel select register
    logic [3:0]             blank_ff;        // Blanking field
    logic [7:0]             result_ff;       // Result register
    logic [7:0]             max_ff;          // Running scan maximum
    logic                   done_ff;         // Conversion done flag
    logic                   err_ff;          // Converter error flag
    logic [3:0]             grp_ff;          // Scan group, 8 means all done
    logic                   sub_ff;          // Member within the group
    logic [TW-1:0]          blank_cnt_ff;    // Blanking countdown
    logic [TW-1:0]          period_cnt_ff;   // Running dimming period count
    logic [TW-1:0]          period_ff;       // Last measured dimming period
    logic [15:0]            on_prev_ff;      // Output on state, last cycle
    logic                   start_ff;        // Converter start pulse
    logic [3:0]             starts_ff;       // Cycle starts since scan began

    logic          restart;                  // Select write or result read
    logic          scan;                     // Max-output code selected
    logic [3:0]    cur_pin;                  // Pin being measured
    logic [3:0]    first_pin;                // First enabled member of the group
    logic [15:0]   rise;                     // Outputs turning on now
    logic [TW-1:0] blank_cycles;             // Blanking delay in cycles
    logic [TW-1:0] need;                     // Blank plus three conversions
    logic          too_short;                // Dimming period below need
    logic          grp_any;                  // Some pin of the group enabled
    logic          done_set;                 // Completion event
    logic          err_set;                  // Timing error event

    // Decode of the current request
    assign restart      = i_select_write | i_result_read;
    assign scan         = (sel_ff == adc_seq_pkg::CODE_HIGHEST_OUTPUT_CHANNEL);
    assign cur_pin      = scan ? {grp_ff[2:0], sub_ff}
                               : adc_seq_pkg::pin_of_code(sel_ff);
    assign first_pin    = {grp_ff[2:0], !i_output_enable_bit[{grp_ff[2:0], 1'b0}]};
    assign rise         = i_output_on & ~on_prev_ff;
    assign blank_cycles = TW'(adc_seq_pkg::blank_us(blank_ff)) * TW'(CYCLES_PER_US);
    assign need         = blank_cycles + TW'(3 * adc_seq_pkg::CONV_CYCLES);
    assign too_short    = (period_ff < need);
    assign grp_any      = |i_output_enable_bit[{grp_ff[2:0], 1'b0} +: 2];
    assign err_set      = (state_ff == adc_seq_pkg::ST_CHECK) && too_short;
    assign done_set     = ((state_ff == adc_seq_pkg::ST_CONVERT) && i_sar_done && !scan)
                        || ((state_ff == adc_seq_pkg::ST_WAIT_CYCLE) && i_dim_cycle_start
                            && (grp_ff == adc_seq_pkg::GROUP_END));

    // Software visible registers
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            sel_ff   <= adc_seq_pkg::CHSEL_RESET;
            blank_ff <= adc_seq_pkg::BLANK_RESET;
        end else begin
            if (i_select_write) begin
                sel_ff <= i_select_data;
            end
            if (i_blank_write) begin
                blank_ff <= i_blank_data;
            end
        end
    end

    // Done and error flags; a set in the same cycle beats a clear
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            done_ff <= 1'b0;
            err_ff  <= 1'b0;
        end else begin
            if (done_set) begin
                done_ff <= 1'b1;
            end else if (restart) begin
                done_ff <= 1'b0;
            end
            if (err_set) begin
                err_ff <= 1'b1;
            end else if (i_fault_clear) begin
                err_ff <= 1'b0;
            end
        end
    end

    // Result register and scan maximum
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            result_ff <= adc_seq_pkg::RESULT_RESET;
            max_ff    <= adc_seq_pkg::RESULT_RESET;
        end else begin
            if (state_ff == adc_seq_pkg::ST_CHECK) begin
                max_ff <= adc_seq_pkg::RESULT_RESET;
            end else if ((state_ff == adc_seq_pkg::ST_CONVERT) && i_sar_done && scan
                         && (i_sar_code > max_ff)) begin
                max_ff <= i_sar_code;
            end
            // Result only changes on a completion
            if (done_set) begin
                result_ff <= scan ? max_ff : i_sar_code;
            end
        end
    end

    // Dimming period measurement between cycle starts
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            period_cnt_ff <= '0;
            period_ff     <= '0;
            on_prev_ff    <= 16'h0000;
        end else begin
            on_prev_ff <= i_output_on;
            if (i_dim_cycle_start) begin
                period_ff     <= period_cnt_ff + TW'(1);
                period_cnt_ff <= '0;
            end else if (period_cnt_ff != '1) begin
                period_cnt_ff <= period_cnt_ff + TW'(1);
            end
        end
    end

    // Count of dimming cycle starts since the sequence began
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            starts_ff <= 4'h0;
        end else if (state_ff == adc_seq_pkg::ST_CHECK) begin
            starts_ff <= 4'h0;
        end else if (i_dim_cycle_start && (starts_ff != 4'hF)) begin
            starts_ff <= starts_ff + 4'h1;
        end
    end

    // Sequencer
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state_ff     <= adc_seq_pkg::ST_IDLE;
            grp_ff       <= 4'h0;
            sub_ff       <= 1'b0;
            blank_cnt_ff <= '0;
            start_ff     <= 1'b0;
        end else begin
            start_ff <= 1'b0;
            if (restart) begin
                // Any start request aborts the run in progress
                state_ff <= adc_seq_pkg::ST_CHECK;
            end else begin
                unique case (state_ff)
                    adc_seq_pkg::ST_IDLE: begin
                        state_ff <= adc_seq_pkg::ST_IDLE;
                    end
                    adc_seq_pkg::ST_CHECK: begin
                        grp_ff <= 4'h0;
                        sub_ff <= 1'b0;
                        if (too_short) begin
                            state_ff <= adc_seq_pkg::ST_IDLE;
                        end else if (scan) begin
                            state_ff <= adc_seq_pkg::ST_WAIT_CYCLE;
                        end else if (adc_seq_pkg::is_pin_code(sel_ff)
                                     && i_output_enable_bit[cur_pin]) begin
                            state_ff <= adc_seq_pkg::ST_WAIT_ON;
                        end else begin
                            // Internal channels and disabled pins convert now
                            state_ff <= adc_seq_pkg::ST_CONVERT;
                            start_ff <= 1'b1;
                        end
                    end
                    adc_seq_pkg::ST_WAIT_CYCLE: begin
                        if (i_dim_cycle_start) begin
                            if (grp_ff == adc_seq_pkg::GROUP_END) begin
                                state_ff <= adc_seq_pkg::ST_IDLE;
                            end else if (!grp_any) begin
                                grp_ff <= grp_ff + 4'h1;
                            end else if (rise[first_pin]) begin
                                // Group switched on with the cycle start; blank from now
                                sub_ff       <= first_pin[0];
                                blank_cnt_ff <= blank_cycles;
                                state_ff     <= adc_seq_pkg::ST_BLANK;
                            end else begin
                                // Phase-shifted group: wait for it to switch on
                                sub_ff   <= first_pin[0];
                                state_ff <= adc_seq_pkg::ST_WAIT_ON;
                            end
                        end
                    end
                    adc_seq_pkg::ST_WAIT_ON: begin
                        if (rise[cur_pin]) begin
                            blank_cnt_ff <= blank_cycles;
                            state_ff     <= adc_seq_pkg::ST_BLANK;
                        end
                    end
                    adc_seq_pkg::ST_BLANK: begin
                        if (blank_cnt_ff <= TW'(1)) begin
                            state_ff <= adc_seq_pkg::ST_CONVERT;
                            start_ff <= 1'b1;
                        end else begin
                            blank_cnt_ff <= blank_cnt_ff - TW'(1);
                        end
                    end
                    adc_seq_pkg::ST_CONVERT: begin
                        if (i_sar_done && !scan) begin
                            state_ff <= adc_seq_pkg::ST_IDLE;
                        end else if (i_sar_done && !sub_ff
                                     && i_output_enable_bit[{grp_ff[2:0], 1'b1}]) begin
                            // Second member while the pair is still on
                            sub_ff   <= 1'b1;
                            start_ff <= 1'b1;
                        end else if (i_sar_done) begin
                            grp_ff   <= grp_ff + 4'h1;
                            state_ff <= adc_seq_pkg::ST_WAIT_CYCLE;
                        end
                    end
                endcase
            end
        end
    end

    // Outputs
    assign o_channel_select        = sel_ff;
    assign o_sample_blanking_delay = blank_ff;
    assign o_conversion_result     = result_ff;
    assign o_conversion_done_flag  = done_ff;
    assign o_converter_error_flag  = err_ff;
    assign o_sar_request           = '{start:   start_ff,
                                       channel: scan ? adc_seq_pkg::code_of_pin(cur_pin) : sel_ff};

    // Checks
    a_select_clears_done: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_select_write && !done_set |=> !o_conversion_done_flag)
        else $error("select write did not clear done");
    a_done_loads_code: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (state_ff == adc_seq_pkg::ST_CONVERT) && i_sar_done && !scan
        |=> o_conversion_done_flag && (o_conversion_result == $past(i_sar_code)))
        else $error("single result not loaded");
    a_read_restarts: assert property (@(posedge i_clock) disable iff (!i_resetn)
        i_result_read |=> (state_ff == adc_seq_pkg::ST_CHECK))
        else $error("result read did not restart");
    a_blank_holds_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (state_ff == adc_seq_pkg::ST_BLANK) && (blank_cnt_ff > TW'(1)) && !restart
        |=> (state_ff == adc_seq_pkg::ST_BLANK) && !o_sar_request.start)
        else $error("sampled before blanking ended");
    a_disabled_now: assert property (@(posedge i_clock) disable iff (!i_resetn)
        (state_ff == adc_seq_pkg::ST_CHECK) && !too_short && !scan && !restart
        && !i_output_enable_bit[cur_pin]
        |=> o_sar_request.start && (state_ff == adc_seq_pkg::ST_CONVERT))
        else $error("disabled pin not sampled at once");
    a_scan_nine_cycles: assert property (@(posedge i_clock) disable iff (!i_resetn)
        done_set && scan |-> (starts_ff >= adc_seq_pkg::SCAN_STARTS - 4'h1))
        else $error("scan finished too early");
    a_scan_skips_off: assert property (@(posedge i_clock) disable iff (!i_resetn)
        scan && o_sar_request.start |-> i_output_enable_bit[cur_pin])
        else $error("disabled pin scanned");
    a_error_aborts: assert property (@(posedge i_clock) disable iff (!i_resetn)
        err_set && !restart |=> o_converter_error_flag
        && (state_ff == adc_seq_pkg::ST_IDLE))
        else $error("short period not flagged");
    a_error_sticky: assert property (@(posedge i_clock) disable iff (!i_resetn)
        o_converter_error_flag && !i_fault_clear |=> o_converter_error_flag)
        else $error("error flag lost without clear");
    a_result_holds: assert property (@(posedge i_clock) disable iff (!i_resetn)
        !done_set |=> $stable(o_conversion_result))
        else $error("result changed without completion");
endmodule : adc_conversion_sequencer
`default_nettype wire

// File: sim/sar_model.sv
// Behavioural model of the analog converter behind the sequencer
`timescale 1ns/100ps
`default_nettype none
module sar_model #(
    parameter int CONV_CYCLES = 20
) (
    // Clock
    input  wire logic                     i_clock,
    // Request and pin state
    input  wire adc_seq_pkg::sar_req_type i_sar_request,
    input  wire logic [15:0]              i_output_on,
    // Answer
    output logic                          o_sar_done,
    output logic [7:0]                    o_sar_code
);
    logic [4:0] off;              // Offset from the first pin code
    logic [4:0] grp;              // Pin group of the code
    logic [4:0] mem;              // Member within the group, 2 is reserved
    logic       pin_on;           // Selected pin is in its on phase
    logic [7:0] code_ff = 8'h00;  // Code captured at start
    logic       done_ff = 1'b0;   // Done pulse
    int         busy    = 0;      // Cycles left in the conversion

    assign off = i_sar_request.channel - 5'h08;
    assign grp = off / 5'd3;
    assign mem = off % 5'd3;
    // Code carries whether the pin was on when sampled
    assign pin_on = (i_sar_request.channel >= 5'h08) && (mem != 5'd2)
                    && i_output_on[{grp[2:0], mem[0]}];

    // Conversion timer; a new start abandons the one in flight
    always_ff @(posedge i_clock) begin
        done_ff <= (busy == 1) && !i_sar_request.start;
        if (i_sar_request.start) begin
            busy    <= CONV_CYCLES;
            code_ff <= {pin_on, 2'b00, i_sar_request.channel};
        end else if (busy != 0) begin
            busy <= busy - 1;
        end
    end

    assign o_sar_done = done_ff;
    // Code is valid only with done; otherwise it shows the inverse
    assign o_sar_code = done_ff ? code_ff : ~code_ff;
endmodule : sar_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic        i_clock    = 1'b0;      // Core clock
    logic        i_resetn   = 1'b0;      // Reset, active low
    logic        sel_wr     = 1'b0;      // Channel select write
    logic [4:0]  sel_d      = 5'h00;     // Channel select data
    logic        blk_wr     = 1'b0;      // Blanking write
    logic [3:0]  blk_d      = 4'h0;      // Blanking code
    logic        rd         = 1'b0;      // Result read
    logic        fclr       = 1'b0;      // Fault clear bit write
    logic [15:0] en         = 16'h7FFF;  // Output enables, top pin off
    logic        dim_start  = 1'b0;      // Dimming cycle start
    logic        pwm_on     = 1'b0;      // Shared on phase
    logic [4:0]  chsel;                  // Select readback
    logic [3:0]  blank;                  // Blanking readback
    logic [7:0]  result;                 // Result register
    logic        done;                   // Done flag
    logic        err;                    // Error flag
    logic        sar_done;               // Converter finished
    logic [7:0]  sar_code;               // Converter code
    adc_seq_pkg::sar_req_type req;       // Converter request
    wire  [15:0] pins_on = en & {16{pwm_on}};
    logic [4:0]  codes [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h07, 5'h0A, 5'h1F};
    int dim_period = 400, dim_cnt = 0, n_dim = 0, cycles = 0, t0 = 0;
    int min_on = 20 + 3 * adc_seq_pkg::CONV_CYCLES; // Blank code 1 plus three conversions
    int miscompares = 0, n_checks = 0;

    adc_conversion_sequencer #(.CYCLES_PER_US(1)) dut_u (
        .i_clock(i_clock), .i_resetn(i_resetn), .i_select_write(sel_wr),
        .i_select_data(sel_d), .i_blank_write(blk_wr), .i_blank_data(blk_d),
        .i_result_read(rd), .i_fault_clear(fclr), .o_channel_select(chsel),
        .o_sample_blanking_delay(blank), .o_conversion_result(result),
        .o_conversion_done_flag(done), .o_converter_error_flag(err),
        .i_output_enable_bit(en), .i_output_on(pins_on), .i_dim_cycle_start(dim_start),
        .o_sar_request(req), .i_sar_done(sar_done), .i_sar_code(sar_code));
    sar_model #(.CONV_CYCLES(20)) sar_u (.i_clock(i_clock), .i_sar_request(req),
        .i_output_on(pins_on), .o_sar_done(sar_done), .o_sar_code(sar_code));

    always #50 i_clock = ~i_clock;

    // Dimming source; on pulse outlasts blank plus three conversions
    always @(posedge i_clock) begin
        #1;
        dim_cnt   = (dim_cnt + 1 >= dim_period) ? 0 : dim_cnt + 1;
        dim_start = (dim_cnt == 0);
        pwm_on    = (dim_period < min_on) || (dim_cnt < dim_period - 20);
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            give_verdict();
        end
    end
    // Dimming starts as the sequencer sees them
    always @(posedge i_clock) begin
        if (dim_start) n_dim++;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : cyc
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    task automatic write_sel(input logic [4:0] c);
        sel_d  = c;
        sel_wr = 1'b1;
        cyc(1);
        sel_wr = 1'b0;
    endtask : write_sel
    task automatic pulse_read();
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
    endtask : pulse_read
    task automatic clear_fault();
        fclr = 1'b1;
        cyc(1);
        fclr = 1'b0;
        cyc(1);
    endtask : clear_fault
    task automatic wait_done(input int lim);
        int k;
        k = 0;
        while (done !== 1'b1 && k < lim) begin
            cyc(1);
            k++;
        end
        check({7'h00, done}, 8'h01, "done flag");
    endtask : wait_done
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        cyc(16);
        i_resetn = 1'b1;
        check({3'h0, chsel}, 8'h00, "select reset");
        check({4'h0, blank}, 8'h00, "blank reset");
        check({6'h00, done, err}, 8'h00, "flags reset");
        check(result, 8'h00, "result reset");
        write_sel(5'h03);
        cyc(2);
        check({7'h00, err}, 8'h01, "start without period");
        cyc(20);
        check({7'h00, err}, 8'h01, "error holds");
        clear_fault();
        check({7'h00, err}, 8'h00, "error cleared");
        $display("Test done: reset and early error");
        blk_d  = 4'h1;
        blk_wr = 1'b1;
        cyc(1);
        blk_wr = 1'b0;
        check({4'h0, blank}, 8'h01, "blank write");
        cyc(800);
        foreach (codes[i]) begin
            write_sel(codes[i]);
            check({7'h00, done}, 8'h00, "done cleared by write");
            check({3'h0, chsel}, {3'h0, codes[i]}, "select readback");
            wait_done(200);
            check(result, {3'h0, codes[i]}, "single result");
        end
        pulse_read();
        check({7'h00, done}, 8'h00, "done cleared by read");
        wait_done(200);
        write_sel(5'h08);
        cyc(5);
        check(result, 8'h1F, "result held");
        wait_done(900);
        check(result, 8'h88, "enabled pin sampled on");
        write_sel(5'h1E);
        wait_done(900);
        check(result, 8'h1E, "disabled pin sampled off");
        $display("Test done: single conversions");
        write_sel(5'h06);
        t0 = n_dim;
        wait_done(4500);
        check({7'h00, (n_dim - t0) >= 9}, 8'h01, "scan length");
        check({7'h00, (n_dim - t0) <= 10}, 8'h01, "one group per cycle");
        check(result, 8'h9D, "scan maximum");
        cyc(900);
        check({done, result[6:0]}, 8'h9D, "scan halted");
        en = 16'h0000; // Every pin off: the next scan maximum must stay empty
        pulse_read();
        check({7'h00, done}, 8'h00, "scan read clears");
        wait_done(4500);
        check(result, 8'h00, "scan restarted, all skipped");
        write_sel(5'h06);
        cyc(800);
        write_sel(5'h03);
        check({7'h00, done}, 8'h00, "write during scan");
        wait_done(200);
        check(result, 8'h03, "restart after scan write");
        $display("Test done: auto scan");
        dim_period = 200;
        cyc(500);
        write_sel(5'h03);
        cyc(2);
        check({7'h00, err}, 8'h01, "short period error");
        cyc(300);
        check({7'h00, done}, 8'h00, "short period aborts");
        clear_fault();
        check({7'h00, err}, 8'h00, "error cleared again");
        $display("Test done: period check");
        give_verdict();
    end
endmodule : tb
`default_nettype wire
